// *** hw/spbe_handler.sv ***
// spbe_handler: per-port self-test entry/hold and link/transport error
// reaction, with a small register file on a plain strobe port.
// assumes link events and detect code come from logic on mclk_i; the
// software port never issues read and write strobes in the same cycle.
//
// How it works
// - port interrupt held until flags cleared
// - far-end loopback request: detect 4h, test
// - any activation frame outside the fatal wait enters and holds test
// - fatal condition held until start cleared
// - sync escape of D2H or data: fatal
// - sync escape non-data: fatal, switching nonfatal
// - R_ERR on data: fatal unless switching, posting continues
// - R_ERR on non-data: nonfatal flag
// - CRC on received data: fatal, keep posting
// - CRC on received non-data: nonfatal flag
// - erroneous set-device-bits: tags, taskfile, device
// - erroneous register frame: taskfile, device record
// - erroneous PIO setup: taskfile, device record
// - DMA setup without active slot: fatal
// - other frame without slot: dropped silently
// - overflow: flag, switching records device too
// - underflow: only write actual byte count
// - running indication cleared once start clear
// - nonfatal handling returns to proper idle
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/100ps
module spbe_handler
  import spbe_pkg::*;
#(
  parameter int DEV_W = 4,
  parameter int TAG_W = 32
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // software register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // link side
  input  wire spbe_evt_t   evt_i,
  input  wire logic        slot_active_i,
  input  wire logic [3:0]  phy_det_i,
  // outcomes
  output logic             fis_post_o,
  output spbe_hdr_t        hdr_o,
  output logic [3:0]       link_detect_state_o,
  output logic             command_list_running_o,
  output logic             selftest_active_o,
  output logic             port_irq_o
);

  // ==========================================================================
  // elaboration checks
  initial begin
    if (DEV_W != 4) begin
      $error("spbe_handler: DEV_W must be 4");
    end
    if (TAG_W < 1 || TAG_W > 32) begin
      $error("spbe_handler: TAG_W must be 1..32");
    end
  end

  // ==========================================================================
  // state
  spbe_state_t       state_r;
  spbe_state_t       state_nxt;
  logic [1:0]        ctrl_r;
  logic              fatal_ifs_r;
  logic              nonfatal_r;
  logic              taskfile_r;
  logic              overflow_r;
  logic              sde_r;
  logic [DEV_W-1:0]  dwe_r;
  logic [TAG_W-1:0]  acttag_r;
  logic [3:0]        det_r;
  logic              cr_r;
  logic [31:0]       rdata_r;
  logic              post_r;
  spbe_hdr_t         hdr_r;

  logic port_start_ctl;
  logic fis_switching_enable;
  assign port_start_ctl       = ctrl_r[SPBE_CTRL_START_BIT];
  assign fis_switching_enable = ctrl_r[SPBE_CTRL_FBS_BIT];

  // ==========================================================================
  // event decode
  logic ev;
  logic is_d2h_fis;
  logic drop_fis;
  logic set_ifs;
  logic set_infs;
  logic set_tfes;
  logic set_ofs;
  logic set_sde;
  logic tag_upd;
  logic to_fatal;
  logic to_nonfat;
  logic bist_fe;
  logic bist_any;
  logic wr_err;
  logic wr_sw;
  logic in_test;

  assign ev      = evt_i.valid;
  assign in_test = (state_r == SPBE_ST_FE_LOOP) || (state_r == SPBE_ST_TEST);

  // frames that would be posted to memory
  always_comb begin
    case (evt_i.kind)
      SPBE_EV_SDB, SPBE_EV_D2H_REG, SPBE_EV_PIO_SETUP,
      SPBE_EV_DMA_SETUP, SPBE_EV_OTHER_D2H: is_d2h_fis = 1'b1;
      default:                              is_d2h_fis = 1'b0;
    endcase
  end

  // a non-DMA frame with no command slot open is swallowed whole
  assign drop_fis = ev && is_d2h_fis && !slot_active_i
                    && (evt_i.kind != SPBE_EV_DMA_SETUP);

  // set conditions per flag; a dropped frame touches nothing
  always_comb begin
    set_ifs  = 1'b0;
    set_infs = 1'b0;
    set_tfes = 1'b0;
    set_ofs  = 1'b0;
    set_sde  = 1'b0;
    tag_upd  = 1'b0;
    bist_fe  = 1'b0;
    bist_any = 1'b0;
    if (ev && !drop_fis && !in_test) begin
      case (evt_i.kind)
        SPBE_EV_BIST_RX_FE: begin
          bist_fe  = 1'b1;
          bist_any = 1'b1;
        end
        SPBE_EV_BIST_RX, SPBE_EV_BIST_TX: bist_any = 1'b1;
        SPBE_EV_SYNC_D2H, SPBE_EV_SYNC_H2D_DAT: set_ifs = 1'b1;
        SPBE_EV_SYNC_H2D_ND: begin
          set_ifs  = !fis_switching_enable;
          set_infs = fis_switching_enable;
          set_sde  = fis_switching_enable;
        end
        SPBE_EV_RERR_DAT: set_ifs = !fis_switching_enable;
        SPBE_EV_RERR_ND:  set_infs = 1'b1;
        SPBE_EV_CRC_DAT:  set_ifs = 1'b1;
        SPBE_EV_CRC_ND:   set_infs = 1'b1;
        SPBE_EV_SDB: begin
          tag_upd  = 1'b1;
          set_tfes = evt_i.sts_err;
          set_sde  = evt_i.sts_err && fis_switching_enable;
        end
        SPBE_EV_D2H_REG, SPBE_EV_PIO_SETUP: begin
          set_tfes = evt_i.sts_err;
          set_sde  = evt_i.sts_err && fis_switching_enable;
        end
        SPBE_EV_DMA_SETUP: set_ifs = !slot_active_i;
        SPBE_EV_OVERFLOW: begin
          set_ofs = 1'b1;
          set_sde = fis_switching_enable;
        end
        default: ;  // underflow raises nothing
      endcase
    end
  end

  // taskfile errors are fatal unless switching handles them per device
  assign to_fatal  = set_ifs || (set_tfes && !fis_switching_enable);
  assign to_nonfat = !to_fatal && (set_infs || set_ofs || set_sde);

  assign wr_err = wr_i && (addr_i == SPBE_OFS_ERR);
  assign wr_sw  = wr_i && (addr_i == SPBE_OFS_SWERR);

  // ==========================================================================
  // handler state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // the nonfatal state decodes new events too, so a frame in its cycle is not lost
      SPBE_ST_IDLE, SPBE_ST_FB_IDLE, SPBE_ST_NONFAT: begin
        if (bist_fe) begin
          state_nxt = SPBE_ST_FE_LOOP;
        end else if (bist_any) begin
          state_nxt = SPBE_ST_TEST;
        end else if (to_fatal) begin
          state_nxt = SPBE_ST_FATAL;
        end else if (to_nonfat) begin
          state_nxt = SPBE_ST_NONFAT;
        end else begin
          state_nxt = fis_switching_enable ? SPBE_ST_FB_IDLE : SPBE_ST_IDLE;
        end
      end
      SPBE_ST_FATAL: begin
        if (!port_start_ctl) begin
          state_nxt = SPBE_ST_IDLE;
        end
      end
      SPBE_ST_FE_LOOP: state_nxt = SPBE_ST_TEST;
      SPBE_ST_TEST: begin
        if (!port_start_ctl) begin
          state_nxt = SPBE_ST_IDLE;
        end
      end
      default: state_nxt = SPBE_ST_IDLE;
    endcase
  end

  // events from the nonfatal state are decoded too, so none is lost
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= SPBE_ST_IDLE;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // control word
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= SPBE_CTRL_RST;
    end else if (ce_i && wr_i && addr_i == SPBE_OFS_CTRL) begin
      ctrl_r <= wdata_i[1:0];
    end
  end

  // ==========================================================================
  // error flags: write one clears, a same-cycle set wins
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fatal_ifs_r <= 1'b0;
      nonfatal_r  <= 1'b0;
      taskfile_r  <= 1'b0;
      overflow_r  <= 1'b0;
    end else if (ce_i) begin
      // the fatal flag cannot be wiped while the port still waits for start low
      if (set_ifs) begin
        fatal_ifs_r <= 1'b1;
      end else if (wr_err && wdata_i[SPBE_ERR_IFS_BIT] && state_r != SPBE_ST_FATAL) begin
        fatal_ifs_r <= 1'b0;
      end
      if (set_infs) begin
        nonfatal_r <= 1'b1;
      end else if (wr_err && wdata_i[SPBE_ERR_INFS_BIT]) begin
        nonfatal_r <= 1'b0;
      end
      if (set_tfes) begin
        taskfile_r <= 1'b1;
      end else if (wr_err && wdata_i[SPBE_ERR_TFES_BIT]) begin
        taskfile_r <= 1'b0;
      end
      if (set_ofs) begin
        overflow_r <= 1'b1;
      end else if (wr_err && wdata_i[SPBE_ERR_OFS_BIT]) begin
        overflow_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // single device error and failing device number
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sde_r <= 1'b0;
      dwe_r <= '0;
    end else if (ce_i) begin
      if (set_sde) begin
        sde_r <= 1'b1;
        dwe_r <= evt_i.pm_port[DEV_W-1:0];
      end else if (wr_sw && wdata_i[SPBE_SW_SDE_BIT]) begin
        sde_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // active tag set: software marks issued tags, set-device-bits retires them
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acttag_r <= '0;
    end else if (ce_i) begin
      if (tag_upd) begin
        acttag_r <= acttag_r & ~evt_i.tags[TAG_W-1:0];
      end else if (wr_i && addr_i == SPBE_OFS_ACTTAG) begin
        acttag_r <= acttag_r | wdata_i[TAG_W-1:0];
      end
    end
  end

  // ==========================================================================
  // link detect code: forced during far-end loopback, held through test, else tracks the phy
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      det_r <= SPBE_DET_RST;
    end else if (ce_i) begin
      if (state_r == SPBE_ST_FE_LOOP) begin
        det_r <= SPBE_DET_LOOPBK;
      end else if (!in_test) begin
        det_r <= phy_det_i;
      end
    end
  end

  // ==========================================================================
  // command list running follows start; dropped one cycle after start goes low
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cr_r <= 1'b0;
    end else if (ce_i) begin
      cr_r <= port_start_ctl;
    end
  end

  // ==========================================================================
  // posting and header update strobes
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      post_r <= 1'b0;
      hdr_r  <= '0;
    end else if (ce_i) begin
      // posting stays open through a fatal wait until start is cleared
      post_r      <= ev && is_d2h_fis && !drop_fis && port_start_ctl && !in_test;
      hdr_r.valid <= ev && (evt_i.kind == SPBE_EV_UNDERFLOW) && !in_test;
      if (ev && evt_i.kind == SPBE_EV_UNDERFLOW) begin
        hdr_r.bytes <= evt_i.tags;
      end
    end
  end

  // ==========================================================================
  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= '0;
    end else if (ce_i) begin
      rdata_r <= '0;
      if (rd_i) begin
        case (addr_i)
          SPBE_OFS_CTRL: rdata_r[1:0] <= ctrl_r;
          SPBE_OFS_STAT: begin
            rdata_r[SPBE_STAT_CR_BIT]                     <= cr_r;
            rdata_r[SPBE_STAT_FATAL_BIT]                  <= (state_r == SPBE_ST_FATAL);
            rdata_r[SPBE_STAT_DET_LSB +: 4]               <= det_r;
            rdata_r[SPBE_STAT_ST_LSB +: 3]                <= state_r;
          end
          SPBE_OFS_ERR: begin
            rdata_r[SPBE_ERR_IFS_BIT]  <= fatal_ifs_r;
            rdata_r[SPBE_ERR_INFS_BIT] <= nonfatal_r;
            rdata_r[SPBE_ERR_TFES_BIT] <= taskfile_r;
            rdata_r[SPBE_ERR_OFS_BIT]  <= overflow_r;
          end
          SPBE_OFS_SWERR: begin
            rdata_r[SPBE_SW_SDE_BIT]           <= sde_r;
            rdata_r[SPBE_SW_DWE_LSB +: DEV_W]  <= dwe_r;
          end
          SPBE_OFS_ACTTAG: rdata_r[TAG_W-1:0] <= acttag_r;
          default: rdata_r <= '0;  // unmapped reads as zero
        endcase
      end
    end
  end

  // ==========================================================================
  // outputs
  assign rdata_o                = rdata_r;
  assign fis_post_o             = post_r;
  assign hdr_o                  = hdr_r;
  assign link_detect_state_o    = det_r;
  assign command_list_running_o = cr_r;
  assign selftest_active_o      = in_test;
  // level from sticky flags: stays up until every flag is cleared
  assign port_irq_o = fatal_ifs_r | nonfatal_r | taskfile_r | overflow_r | sde_r;

endmodule : spbe_handler

// *** shared/spbe_pkg.sv ***
// spbe_pkg: constants, event kinds, states and carriers of the port
// self-test and error handler.
// assumes one 250 MHz controller clock shared by every user of this package.
package spbe_pkg;

  // ==========================================================================
  // register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] SPBE_OFS_CTRL   = 8'h00;  // port start, switching enable
  localparam logic [7:0] SPBE_OFS_STAT   = 8'h04;  // running, detect, state
  localparam logic [7:0] SPBE_OFS_ERR    = 8'h08;  // error flags, write one to clear
  localparam logic [7:0] SPBE_OFS_SWERR  = 8'h0c;  // failing device, single device error
  localparam logic [7:0] SPBE_OFS_ACTTAG = 8'h10;  // active tag set

  // control word fields
  localparam int SPBE_CTRL_START_BIT = 0;
  localparam int SPBE_CTRL_FBS_BIT   = 1;
  // status word fields
  localparam int SPBE_STAT_CR_BIT    = 0;
  localparam int SPBE_STAT_FATAL_BIT = 1;
  localparam int SPBE_STAT_DET_LSB   = 4;
  localparam int SPBE_STAT_ST_LSB    = 8;
  // error word fields
  localparam int SPBE_ERR_IFS_BIT    = 0;
  localparam int SPBE_ERR_INFS_BIT   = 1;
  localparam int SPBE_ERR_TFES_BIT   = 2;
  localparam int SPBE_ERR_OFS_BIT    = 3;
  // switching error word fields
  localparam int SPBE_SW_SDE_BIT     = 0;
  localparam int SPBE_SW_DWE_LSB     = 8;

  // reset values and fixed codes
  localparam logic [1:0] SPBE_CTRL_RST    = 2'h0;
  localparam logic [3:0] SPBE_DET_LOOPBK  = 4'h4;  // detect code during far-end loopback
  localparam logic [3:0] SPBE_DET_RST     = 4'h0;

  // ==========================================================================
  // link and transport events, one per cycle at most
  typedef enum logic [4:0] {
    SPBE_EV_BIST_RX_FE   = 5'h00,  // self-test activation received, far-end loopback
    SPBE_EV_BIST_RX      = 5'h01,  // self-test activation received, other mode
    SPBE_EV_BIST_TX      = 5'h02,  // self-test activation sent
    SPBE_EV_SYNC_D2H     = 5'h03,
    SPBE_EV_SYNC_H2D_DAT = 5'h04,
    SPBE_EV_SYNC_H2D_ND  = 5'h05,
    SPBE_EV_RERR_DAT     = 5'h06,
    SPBE_EV_RERR_ND      = 5'h07,
    SPBE_EV_CRC_DAT      = 5'h08,
    SPBE_EV_CRC_ND       = 5'h09,
    SPBE_EV_SDB          = 5'h0a,  // set device bits frame received
    SPBE_EV_D2H_REG      = 5'h0b,
    SPBE_EV_PIO_SETUP    = 5'h0c,
    SPBE_EV_DMA_SETUP    = 5'h0d,
    SPBE_EV_OTHER_D2H    = 5'h0e,
    SPBE_EV_OVERFLOW     = 5'h0f,
    SPBE_EV_UNDERFLOW    = 5'h10
  } spbe_ev_kind_t;

  typedef struct packed {
    logic          valid;     // one-cycle strobe
    spbe_ev_kind_t kind;
    logic [3:0]    pm_port;   // device number carried by the frame
    logic          sts_err;   // error bit of status or ending status
    logic [31:0]   tags;      // completed tags (set device bits) or byte count
  } spbe_evt_t;

  typedef struct packed {
    logic          valid;     // one-cycle strobe: write byte count to header
    logic [31:0]   bytes;
  } spbe_hdr_t;

  // handler states, gray along idle -> error -> wait and idle -> self-test
  typedef enum logic [2:0] {
    SPBE_ST_IDLE    = 3'b000,
    SPBE_ST_NONFAT  = 3'b001,
    SPBE_ST_FATAL   = 3'b011,
    SPBE_ST_FB_IDLE = 3'b010,
    SPBE_ST_FE_LOOP = 3'b110,
    SPBE_ST_TEST    = 3'b111
  } spbe_state_t;

endpackage : spbe_pkg

// *** tb/spbe_handler_properties.sv ***
// spbe_handler_properties: port-level checks of the self-test and error handler.
// assumes one clock domain and the event and offset codes of spbe_pkg.
`timescale 1ns/100ps
module spbe_handler_properties
  import spbe_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        ce_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire spbe_evt_t   evt_i,
  input wire logic        slot_active_i,
  input wire logic [3:0]  phy_det_i,
  input wire logic        fis_post_o,
  input wire spbe_hdr_t   hdr_o,
  input wire logic [3:0]  link_detect_state_o,
  input wire logic        command_list_running_o,
  input wire logic        selftest_active_o,
  input wire logic        port_irq_o
);
  // ====================
  // helpers
  // an event the handler really takes; writes excluded since they may clear flags
  logic tk;
  logic stop_wr;
  assign tk      = evt_i.valid && ce_i && !selftest_active_o && !wr_i;
  assign stop_wr = wr_i && ce_i && addr_i == SPBE_OFS_CTRL && !wdata_i[SPBE_CTRL_START_BIT];

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ====================
  // assertions
  rdata_idle_a: assert property (ce_i && !rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside read cycle");
  irq_hold_a: assert property (port_irq_o && !wr_i |=> port_irq_o)
    else $error("port interrupt dropped without a write");
  fe_loop_a: assert property (tk && evt_i.kind == SPBE_EV_BIST_RX_FE ##1 !wr_i
    |=> selftest_active_o && link_detect_state_o == SPBE_DET_LOOPBK)
    else $error("far-end loopback entry wrong");
  bist_enter_a: assert property (tk && evt_i.kind inside {SPBE_EV_BIST_RX_FE,
    SPBE_EV_BIST_RX, SPBE_EV_BIST_TX} |=> selftest_active_o)
    else $error("self-test not entered");
  // the exit lands two cycles after the stop write, and start must have been set to hold at all
  test_hold_a: assert property (selftest_active_o && command_list_running_o
    && !stop_wr && !$past(stop_wr) |=> selftest_active_o)
    else $error("self-test left without start cleared");
  sync_fatal_a: assert property (tk && evt_i.kind == SPBE_EV_SYNC_D2H |=> port_irq_o [*3])
    else $error("sync escape did not hold interrupt");
  running_clear_a: assert property (stop_wr ##1 !wr_i |=> !command_list_running_o)
    else $error("running indication not cleared");
  drop_silent_a: assert property (tk && evt_i.kind == SPBE_EV_OTHER_D2H && !slot_active_i
    |=> !fis_post_o && !hdr_o.valid && $stable(port_irq_o))
    else $error("orphan frame not dropped");
  underflow_count_a: assert property (tk && evt_i.kind == SPBE_EV_UNDERFLOW
    |=> hdr_o.valid && hdr_o.bytes == $past(evt_i.tags) && $stable(port_irq_o))
    else $error("underflow byte count wrong");
  error_raise_a: assert property (tk && (evt_i.kind == SPBE_EV_OVERFLOW ||
    (evt_i.kind == SPBE_EV_DMA_SETUP && !slot_active_i)) |=> port_irq_o)
    else $error("error flag not raised");
endmodule : spbe_handler_properties

bind spbe_handler spbe_handler_properties u_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .evt_i(evt_i),
  .slot_active_i(slot_active_i), .phy_det_i(phy_det_i), .fis_post_o(fis_post_o), .hdr_o(hdr_o),
  .link_detect_state_o(link_detect_state_o), .command_list_running_o(command_list_running_o),
  .selftest_active_o(selftest_active_o), .port_irq_o(port_irq_o));

// *** tb/spbe_link_model.sv ***
// spbe_link_model: attached drive or port multiplier, reduced to frame events.
// assumes the bench calls send; one event per call, held one cycle.
`timescale 1ns/100ps
module spbe_link_model
  import spbe_pkg::*;
(
  input  wire logic  mclk_i,
  output spbe_evt_t  evt_o,
  output logic       slot_o,
  output logic [3:0] det_o
);
  logic        req_r;
  spbe_evt_t   hold_r;
  logic [41:0] noise_r;

  // ====================
  // event line
  // outside an event the fields churn, so stale values can never look valid
  initial begin
    req_r   = 1'b0;
    hold_r  = '0;
    noise_r = '0;
    slot_o  = 1'b1;
  end
  assign det_o = 4'h3;
  always @(posedge mclk_i) begin
    noise_r <= noise_r + 42'h1555;
  end
  assign evt_o = req_r ? hold_r : spbe_evt_t'({1'b0, noise_r});

  // one frame event from device number 5 with its error bit set
  task automatic send(input spbe_ev_kind_t k, input logic s, input logic [31:0] t);
    @(posedge mclk_i);
    slot_o <= s;
    hold_r <= {1'b1, k, 4'h5, 1'b1, t};
    req_r  <= 1'b1;
    @(posedge mclk_i);
    req_r  <= 1'b0;
  endtask : send
endmodule : spbe_link_model

// *** tb/spbe_handler_bench.sv ***
// spbe_handler_bench: register-port tests of the self-test and error handler.
// assumes spbe_link_model as the far side and the checker bound to the design.
`timescale 1ns/100ps
module spbe_handler_bench;
  import spbe_pkg::*;
  typedef struct {spbe_ev_kind_t k; logic f; logic s; logic [3:0] e; logic [31:0] w;} spbe_case_t;
  logic        mclk_i, rst_n_i, wr_i, rd_i, post, run, stest, irq, slot, fat, ce;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [3:0]  phy, det_o;
  spbe_evt_t   evt;
  spbe_hdr_t   hdr;
  int          fail_count, total_checks;
  // normal-mode rows first: the failing device field is never cleared
  spbe_case_t  tbl[17] = '{
    '{SPBE_EV_SYNC_D2H,     1'b0, 1'b1, 4'h1, 32'h0},
    '{SPBE_EV_SYNC_H2D_DAT, 1'b0, 1'b1, 4'h1, 32'h0},
    '{SPBE_EV_SYNC_H2D_ND,  1'b0, 1'b1, 4'h1, 32'h0},
    '{SPBE_EV_RERR_DAT,     1'b0, 1'b1, 4'h1, 32'h0},
    '{SPBE_EV_RERR_ND,      1'b0, 1'b1, 4'h2, 32'h0},
    '{SPBE_EV_CRC_DAT,      1'b0, 1'b1, 4'h1, 32'h0},
    '{SPBE_EV_CRC_ND,       1'b0, 1'b1, 4'h2, 32'h0},
    '{SPBE_EV_D2H_REG,      1'b0, 1'b1, 4'h4, 32'h0},
    '{SPBE_EV_DMA_SETUP,    1'b0, 1'b0, 4'h1, 32'h0},
    '{SPBE_EV_OTHER_D2H,    1'b0, 1'b0, 4'h0, 32'h0},
    '{SPBE_EV_UNDERFLOW,    1'b0, 1'b1, 4'h0, 32'h0},
    '{SPBE_EV_SYNC_H2D_ND,  1'b1, 1'b1, 4'h2, 32'h501},
    '{SPBE_EV_SDB,          1'b1, 1'b1, 4'h4, 32'h501},
    '{SPBE_EV_D2H_REG,      1'b1, 1'b1, 4'h4, 32'h501},
    '{SPBE_EV_PIO_SETUP,    1'b1, 1'b1, 4'h4, 32'h501},
    '{SPBE_EV_OVERFLOW,     1'b1, 1'b1, 4'h8, 32'h501},
    '{SPBE_EV_RERR_DAT,     1'b1, 1'b1, 4'h0, 32'h500}};
  spbe_ev_kind_t bk[3] = '{SPBE_EV_BIST_RX_FE, SPBE_EV_BIST_RX, SPBE_EV_BIST_TX};

  // ====================
  // clock, design and far side
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  spbe_handler DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .evt_i(evt), .slot_active_i(slot), .phy_det_i(phy),
    .fis_post_o(post), .hdr_o(hdr), .link_detect_state_o(det_o), .command_list_running_o(run),
    .selftest_active_o(stest), .port_irq_o(irq));
  spbe_link_model link (.mclk_i(mclk_i), .evt_o(evt), .slot_o(slot), .det_o(phy));

  // ====================
  // compare, register access and verdict
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe, so sample right there
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1 check(nm, e, rdata_o);
  endtask : rd_chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // a hang counts as a mismatch
  initial begin
    #200us;
    fail_count++;
    test_done();
  end

  // ====================
  // tests
  initial begin
    rst_n_i = 1'b0;
    ce      = 1'b1;
    wr_i    = 1'b0;
    rd_i    = 1'b0;
    addr_i  = 8'h00;
    wdata_i = 32'h0;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd_chk(SPBE_OFS_CTRL, 32'h0, "control reset");
    rd_chk(SPBE_OFS_STAT, 32'h30, "status reset");
    rd_chk(SPBE_OFS_ERR, 32'h0, "flags reset");
    rd_chk(8'h14, 32'h0, "unmapped read");
    $display("test reset done");
    foreach (tbl[i]) begin
      wr_reg(SPBE_OFS_CTRL, {30'h0, tbl[i].f, 1'b1});
      wr_reg(SPBE_OFS_ACTTAG, 32'hff);
      link.send(tbl[i].k, tbl[i].s, 32'h0f);
      #1 check("header write", {31'h0, tbl[i].k == SPBE_EV_UNDERFLOW}, {31'h0, hdr.valid});
      rd_chk(SPBE_OFS_ERR, {28'h0, tbl[i].e}, "error flags");
      rd_chk(SPBE_OFS_SWERR, tbl[i].w, "device error");
      rd_chk(SPBE_OFS_ACTTAG, (tbl[i].k == SPBE_EV_SDB) ? 32'hf0 : 32'hff, "active tags");
      fat = tbl[i].e[0] || (tbl[i].e[2] && !tbl[i].f);
      if (fat || tbl[i].e[1] || tbl[i].e[2]) begin
        rd_chk(SPBE_OFS_STAT, {21'h0, fat ? SPBE_ST_FATAL : (tbl[i].f ? SPBE_ST_FB_IDLE : SPBE_ST_IDLE),
          4'h3, 2'b0, fat, 1'b1}, "handler state");
      end
      // a fatal wait must still let frames through to memory until start is cleared
      if (tbl[i].e[0]) begin
        wr_reg(SPBE_OFS_ERR, 32'hf);
        rd_chk(SPBE_OFS_ERR, {28'h0, tbl[i].e}, "fatal held");
        link.send(SPBE_EV_D2H_REG, 1'b1, 32'h0);
        #1 check("posting kept", 32'h1, {31'h0, post});
      end
      wr_reg(SPBE_OFS_CTRL, 32'h0);
      wr_reg(SPBE_OFS_ERR, 32'hf);
      wr_reg(SPBE_OFS_SWERR, 32'h1);
      #1 check("interrupt cleared", 32'h0, {31'h0, irq});
      check("running cleared", 32'h0, {31'h0, run});
    end
    $display("test error table done");
    foreach (bk[j]) begin
      wr_reg(SPBE_OFS_CTRL, 32'h1);
      link.send(bk[j], 1'b1, 32'h0);
      repeat (2) @(posedge mclk_i);
      #1 check("self-test entered", 32'h1, {31'h0, stest});
      if (j == 0) begin
        check("loopback detect", 32'h4, {28'h0, det_o});
      end
      link.send(SPBE_EV_SYNC_D2H, 1'b1, 32'h0);
      wr_reg(SPBE_OFS_CTRL, 32'h3);
      #1 check("self-test held", 32'h1, {31'h0, stest});
      check("event ignored", 32'h0, {31'h0, irq});
      wr_reg(SPBE_OFS_CTRL, 32'h0);
      @(posedge mclk_i);
      #1 check("self-test left", 32'h0, {31'h0, stest});
    end
    $display("test self-test done");
    // with the enable low an event must leave every flag untouched
    @(posedge mclk_i);
    ce <= 1'b0;
    link.send(SPBE_EV_SYNC_D2H, 1'b1, 32'h0);
    #1 check("frozen interrupt", 32'h0, {31'h0, irq});
    @(posedge mclk_i);
    ce <= 1'b1;
    rd_chk(SPBE_OFS_ERR, 32'h0, "frozen flags");
    $display("test clock enable done");
    test_done();
  end
endmodule : spbe_handler_bench
